// *** hw/acs_pkg.sv ***
package acs_pkg;
   // Data path widths
   localparam int RAW_W     = 24;
   localparam int ACC_W     = 33;
   localparam int COEF_W    = 24;
   localparam int MODE_W    = 3;
   // Calibration mode codes
   localparam logic [2:0] MODE_NONE    = 3'h0;
   localparam logic [2:0] MODE_SELF    = 3'h1;
   localparam logic [2:0] MODE_SYS_ZS  = 3'h2;
   localparam logic [2:0] MODE_SYS_FS  = 3'h3;
   localparam logic [2:0] MODE_SYS_OFS = 3'h4;
   localparam logic [2:0] MODE_BGND    = 3'h5;
   // Input node selection driven to the modulator mux
   localparam logic [1:0] SRC_AIN   = 2'h0;
   localparam logic [1:0] SRC_SHORT = 2'h1;
   localparam logic [1:0] SRC_REF   = 2'h2;
   // Timing: 40 MHz master clock, divider in cycles, settle and background ratio in filter outputs
   localparam int MCLK_HZ       = 40000000;
   localparam int MOD_DIV       = 256;
   localparam int SETTLE_CONV   = 3;
   localparam int BGND_RATIO    = 6;
   // Reset values, bipolar midscale and gain fraction width
   localparam logic [23:0] OFFSET_RST = 24'h000000;
   localparam logic [23:0] GAIN_RST   = 24'h800000;
   localparam logic [23:0] BIP_MID    = 24'h800000;
   localparam int GAIN_FRAC = 23;
   // Full-scale target used for slope: 2^23 units per span
   localparam logic [32:0] FS_TARGET  = 33'h000800000;
endpackage

// *** hw/acs_mod_tick.sv ***
`timescale 1ns/1ps
module acs_mod_tick #(
   parameter int DIV = 256
)(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic clear_in,
   // Modulator cycle enable
   output logic      tick_out
);
   localparam int CNT_W = $clog2(DIV);
   logic [CNT_W-1:0]      count;

   // Every rate derives from the master clock by division
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         count    <= '0;
         tick_out <= 1'b0;
      end
      else if (clear_in)
      begin
         count    <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         tick_out <= (count == CNT_W'(DIV - 1));
         count    <= (count == CNT_W'(DIV - 1)) ? '0
                     : count + 1'b1;
      end
   end
endmodule

// *** hw/acs_cal_ctrl.sv ***
`timescale 1ns/1ps
// Overview of operation
// - All rates divide down from master clock
// - Sync falling edge resets filter state
// - Every calibration command resets the filter
// - Capture zero and full scale, compute slope
// - Host may write offset and gain coefficients
// - Subtract offset, then multiply by gain
// - Ready low marks calibration completion
// - Ready rises within one modulator cycle
// - Code 001: shorted then reference, self cal
// - Self cal ready after resettling to input
// - Self cal uses selected gain stage
// - Bipolar self cal uses midscale and full
// - Code 010: input zero-scale step, ready low
// - Code 011: input full-scale step, ready low
// - System cal bipolar uses midscale endpoint
// - Repeated step one keeps slope unchanged
// - Code 100: input zero, reference span
// - Code 101: background cal, rate over six
module acs_cal_ctrl
   import acs_pkg::*;
#(
   parameter int MOD_DIV_P = acs_pkg::MOD_DIV,
   parameter int SETTLE_P  = acs_pkg::SETTLE_CONV
)(
   // Clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      sys_rst_in,
   // Host control
   input  wire logic [acs_pkg::MODE_W-1:0] calibration_mode_field_in,
   input  wire logic                      mode_write_in,
   input  wire logic                      bipolar_in,
   input  wire logic [2:0]                programmable_gain_stage_in,
   input  wire logic                      sync_n_in,
   // Coefficient access
   input  wire logic                      offset_write_in,
   input  wire logic                      gain_write_in,
   input  wire logic [acs_pkg::COEF_W-1:0] coef_data_in,
   // Filter output, one word per output update
   input  wire logic                      filt_valid_in,
   input  wire logic [acs_pkg::RAW_W-1:0] filt_data_in,
   // Modulator and filter control
   output logic [1:0]                     input_select_out,
   output logic [2:0]                     cal_gain_out,
   output logic                           filter_reset_out,
   output logic                           mod_tick_out,
   // Results and status
   output logic [acs_pkg::RAW_W-1:0]      result_out,
   output logic                           result_valid_out,
   output logic                           result_ready_n_out,
   output logic                           cal_busy_out,
   output logic [acs_pkg::COEF_W-1:0]     offset_coef_out,
   output logic [acs_pkg::COEF_W-1:0]     gain_coef_out
);
   import acs_pkg::*;

   typedef enum {
      ST_IDLE, ST_ZERO, ST_FULL, ST_CALC, ST_SETTLE
   } acs_state_t;

   acs_state_t        state;
   logic [2:0]        mode;
   logic              bgnd_on;
   logic [2:0]        bgnd_cnt;
   logic [1:0]        settle_cnt;
   logic [RAW_W-1:0]  zero_raw;
   logic [RAW_W-1:0]  full_raw;
   logic              sync_m;
   logic              sync_s;
   logic              sync_d;
   logic              sync_fall;
   logic              cal_cmd;
   logic              tick;
   logic [ACC_W-1:0]  span;
   logic [ACC_W-1:0]  next_gain;
   logic [ACC_W-1:0]  diff;
   logic [ACC_W+COEF_W-1:0] prod;
   logic [ACC_W-1:0]  scaled;
   logic [RAW_W-1:0]  zero_pt;

   // Pin synchroniser; the edge detect compares the second and third stages
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sync_m <= 1'b1;
         sync_s <= 1'b1;
         sync_d <= 1'b1;
      end
      else
      begin
         sync_m <= sync_n_in;
         sync_s <= sync_m;
         sync_d <= sync_s;
      end
   end
   assign sync_fall = sync_d & ~sync_s;

   // Codes 001..101 are calibration commands; others only end background mode
   assign cal_cmd = mode_write_in
                    && calibration_mode_field_in >= MODE_SELF
                    && calibration_mode_field_in <= MODE_BGND;

   acs_mod_tick #(
      .DIV(MOD_DIV_P)
   ) u_tick (
      .clk_in    (clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in  (sync_fall | cal_cmd),
      .tick_out  (tick)
   );

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         mod_tick_out <= 1'b0;
      else
         mod_tick_out <= tick;
   end

   // Filter reset on sync edge or any calibration command
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         filter_reset_out <= 1'b1;
      else
         filter_reset_out <= sync_fall | cal_cmd;
   end

   // Self cal reuses the selected gain stage setting
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         cal_gain_out <= 3'h0;
      else
         cal_gain_out <= programmable_gain_stage_in;
   end

   // Bipolar calibrations measure from midscale
   assign zero_pt = bipolar_in ? BIP_MID : '0;

   // Slope: full-scale target divided by the measured span, Q1.23
   assign span = {9'h000, full_raw} - {9'h000, zero_raw};
   always_comb
   begin
      next_gain = {9'h000, gain_coef_out};
      if (span != '0)
         next_gain = ACC_W'((48'(FS_TARGET) << GAIN_FRAC) / 48'(span));
   end

   // Calibration sequencer
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state      <= ST_IDLE;
         mode       <= MODE_NONE;
         bgnd_on    <= 1'b0;
         settle_cnt <= '0;
         zero_raw   <= '0;
         full_raw   <= '0;
      end
      else if (cal_cmd)
      begin
         mode       <= calibration_mode_field_in;
         bgnd_on    <= (calibration_mode_field_in == MODE_BGND);
         settle_cnt <= '0;
         // Step two starts straight at full scale
         state      <= (calibration_mode_field_in == MODE_SYS_FS) ?
                       ST_FULL : ST_ZERO;
      end
      else if (mode_write_in)
      begin
         // Leaving background mode only on a mode change
         bgnd_on <= 1'b0;
      end
      else if (sync_fall)
      begin
         state      <= bgnd_on ? ST_ZERO : ST_IDLE;
         settle_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (bgnd_on && filt_valid_in && bgnd_cnt == 3'(BGND_RATIO - 1))
                  state <= ST_ZERO;
            end
            ST_ZERO:
            begin
               if (filt_valid_in && !filter_reset_out)
               begin
                  zero_raw <= filt_data_in - zero_pt;
                  // Step one of system cal ends after the zero point
                  state <= (mode == MODE_SYS_ZS) ? ST_SETTLE : ST_FULL;
               end
            end
            ST_FULL:
            begin
               if (filt_valid_in && !filter_reset_out)
               begin
                  full_raw <= filt_data_in;
                  state    <= ST_CALC;
               end
            end
            ST_CALC:
               state <= ST_SETTLE;
            ST_SETTLE:
            begin
               // Wait for filter to resettle to the live input
               if (filt_valid_in)
               begin
                  settle_cnt <= settle_cnt + 1'b1;
                  if (settle_cnt == 2'(SETTLE_P - 1) || mode == MODE_SYS_ZS
                      || mode == MODE_SYS_FS)
                  begin
                     settle_cnt <= '0;
                     state      <= ST_IDLE;
                  end
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Background interleave counter: one cal per six outputs
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         bgnd_cnt <= '0;
      else if (!bgnd_on || cal_cmd)
         bgnd_cnt <= '0;
      else if (state == ST_IDLE && filt_valid_in)
         bgnd_cnt <= (bgnd_cnt == 3'(BGND_RATIO - 1)) ? '0
                     : bgnd_cnt + 1'b1;
   end

   // Modulator node: shorted for self/background, ref for span except code 011, which spans on the input
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         input_select_out <= SRC_AIN;
      else if (state == ST_ZERO)
         input_select_out <= (mode == MODE_SELF || mode == MODE_BGND) ?
                             SRC_SHORT : SRC_AIN;
      else if (state == ST_FULL)
         input_select_out <= (mode == MODE_SYS_FS) ? SRC_AIN
                             : SRC_REF;
      else
         input_select_out <= SRC_AIN;
   end

   // Coefficient registers; host writes override measurement
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         offset_coef_out <= OFFSET_RST;
         gain_coef_out   <= GAIN_RST;
      end
      else
      begin
         if (offset_write_in)
            offset_coef_out <= coef_data_in;
         else if (state == ST_ZERO && filt_valid_in && !sync_fall
                  && !cal_cmd && !mode_write_in && !filter_reset_out)
            offset_coef_out <= filt_data_in - zero_pt;
         if (gain_write_in)
            gain_coef_out <= coef_data_in;
         else if (state == ST_CALC && !cal_cmd && !mode_write_in
                  && !sync_fall)
            // Step one alone never reaches here: slope kept
            gain_coef_out <= next_gain[COEF_W-1:0];
      end
   end

   // Correction: subtract offset first, then scale
   assign diff   = {9'h000, filt_data_in} - {9'h000, offset_coef_out};
   assign prod   = diff * {9'h000, gain_coef_out};
   assign scaled = prod[GAIN_FRAC +: ACC_W];

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         result_out       <= '0;
         result_valid_out <= 1'b0;
      end
      else
      begin
         result_valid_out <= filt_valid_in && state == ST_IDLE;
         if (filt_valid_in && state == ST_IDLE)
            result_out <= scaled[RAW_W-1:0];
      end
   end

   // Ready: high from a command until completion, low on completion or fresh result
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         result_ready_n_out <= 1'b1;
         cal_busy_out       <= 1'b0;
      end
      else
      begin
         cal_busy_out <= (state != ST_IDLE) || cal_cmd;
         if (cal_cmd)
            result_ready_n_out <= 1'b1;
         else if (state == ST_SETTLE && state != ST_IDLE && filt_valid_in
                  && (settle_cnt == 2'(SETTLE_P - 1) || mode == MODE_SYS_ZS
                      || mode == MODE_SYS_FS))
            result_ready_n_out <= 1'b0;
         else if (filt_valid_in && state == ST_IDLE)
            result_ready_n_out <= 1'b0;
      end
   end

   default clocking acs_dclk @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_cmd_filter_reset: assert property (
      cal_cmd |=> filter_reset_out)
      else $error("calibration command without filter reset");

   a_sync_filter_reset: assert property (
      sync_fall |=> filter_reset_out)
      else $error("sync edge without filter reset");

   a_cmd_ready_high: assert property (
      cal_cmd |=> result_ready_n_out && cal_busy_out)
      else $error("ready not raised after command");

   a_noncal_keeps_coef: assert property (
      (mode_write_in && !cal_cmd && state == ST_IDLE && !offset_write_in
       && !gain_write_in) |=> $stable({offset_coef_out, gain_coef_out}))
      else $error("non-calibration code changed coefficients");

   a_step_one_slope: assert property (
      (mode == MODE_SYS_ZS && state != ST_IDLE && !gain_write_in && !cal_cmd)
      |=> $stable(gain_coef_out))
      else $error("step one altered slope");

   a_self_nodes: assert property (
      (state == ST_ZERO && mode == MODE_SELF)
      |=> input_select_out == SRC_SHORT)
      else $error("self cal zero not on shorted node");

   a_ofs_ref_node: assert property (
      (state == ST_FULL && mode == MODE_SYS_OFS)
      |=> input_select_out == SRC_REF)
      else $error("offset cal span not on reference");

   a_offset_write: assert property (
      offset_write_in |=> offset_coef_out == $past(coef_data_in))
      else $error("offset write lost");

   a_gain_follows: assert property (
      1'b1 |=> cal_gain_out == $past(programmable_gain_stage_in))
      else $error("gain stage not followed");
endmodule

// *** verification/acs_filt_model.sv ***
`timescale 1ns/1ps
module acs_filt_model
   import acs_pkg::*;
#(
   parameter int          OUT_TICKS = 4,
   parameter logic [23:0] SHORT_LVL = 24'h000050,
   parameter logic [23:0] REF_LVL   = 24'h800050
)(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   // Modulator control from the block
   input  wire logic        tick_in,
   input  wire logic        filter_reset_in,
   input  wire logic [1:0]  input_select_in,
   input  wire logic [23:0] ain_level_in,
   // Filter words to the block
   output logic             filt_valid_out,
   output logic [23:0]      filt_data_out
);
   int          ticks;
   logic [1:0]  prev_sel;
   // Node switch restarts the average, as a real filter must resettle
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ticks <= 0;
         prev_sel <= SRC_AIN;
         filt_valid_out <= 1'b0;
         filt_data_out <= 24'hA5A5A5;
      end
      else if (filter_reset_in || input_select_in != prev_sel)
      begin
         ticks <= 0;
         prev_sel <= input_select_in;
         filt_valid_out <= 1'b0;
         filt_data_out <= ~filt_data_out;
      end
      else if (tick_in && ticks == OUT_TICKS - 1)
      begin
         ticks <= 0;
         filt_valid_out <= 1'b1;
         case (input_select_in)
            SRC_SHORT: filt_data_out <= SHORT_LVL;
            SRC_REF:   filt_data_out <= REF_LVL;
            default:   filt_data_out <= ain_level_in;
         endcase
      end
      else
      begin
         // Stale word must not look valid between outputs
         ticks <= ticks + (tick_in ? 1 : 0);
         filt_valid_out <= 1'b0;
         filt_data_out <= ~filt_data_out;
      end
   end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
   import acs_pkg::*;
   localparam int          MDIV  = 16;
   localparam logic [23:0] SHORT = 24'h000050;
   localparam logic [23:0] REFL  = 24'h800050;
   localparam logic [23:0] PO    = 24'h000007;
   localparam logic [23:0] PG    = 24'h111111;
   localparam logic [23:0] G_EXP = 24'(48'h400000000000 / 48'(REFL - SHORT));
   logic        clk_in;
   logic        sys_rst_in;
   logic [2:0]  mode;
   logic        mode_wr;
   logic        bipolar;
   logic [2:0]  gain_sel;
   logic        sync_n;
   logic        off_wr;
   logic        gain_wr;
   logic [23:0] coef;
   logic [23:0] ain;
   logic        fvalid;
   logic [23:0] fdata;
   logic [1:0]  sel;
   logic [2:0]  cgain;
   logic        frst;
   logic        tick;
   logic [23:0] res;
   logic        res_v;
   logic        rdy_n;
   logic        busy;
   logic [23:0] ocoef;
   logic [23:0] gcoef;
   logic [1:0]  hist[$];
   logic [1:0]  last_sel;
   logic        hit;
   int          i;
   int          n_errors;
   int          comparisons;

   acs_cal_ctrl #(.MOD_DIV_P(MDIV), .SETTLE_P(3)) i_acs_cal_ctrl (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .calibration_mode_field_in(mode), .mode_write_in(mode_wr),
      .bipolar_in(bipolar), .programmable_gain_stage_in(gain_sel),
      .sync_n_in(sync_n), .offset_write_in(off_wr),
      .gain_write_in(gain_wr), .coef_data_in(coef),
      .filt_valid_in(fvalid), .filt_data_in(fdata),
      .input_select_out(sel), .cal_gain_out(cgain),
      .filter_reset_out(frst), .mod_tick_out(tick),
      .result_out(res), .result_valid_out(res_v),
      .result_ready_n_out(rdy_n), .cal_busy_out(busy),
      .offset_coef_out(ocoef), .gain_coef_out(gcoef));

   acs_filt_model #(.SHORT_LVL(SHORT), .REF_LVL(REFL)) i_acs_filt_model (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .tick_in(tick),
      .filter_reset_in(frst), .input_select_in(sel),
      .ain_level_in(ain), .filt_valid_out(fvalid),
      .filt_data_out(fdata));

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   always @(negedge clk_in)
      if (sel !== last_sel)
      begin
         hist.push_back(sel);
         last_sel = sel;
      end

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [2:0] code);
      @(posedge clk_in);
      mode <= code;
      mode_wr <= 1'b1;
      @(posedge clk_in);
      mode_wr <= 1'b0;
   endtask

   task automatic wcoef(input logic [23:0] o, input logic [23:0] g);
      @(posedge clk_in);
      coef <= o;
      off_wr <= 1'b1;
      @(posedge clk_in);
      off_wr <= 1'b0;
      coef <= g;
      gain_wr <= 1'b1;
      @(posedge clk_in);
      gain_wr <= 1'b0;
   endtask

   // Kinds: 0 filter reset, 1 ready low, 2 result, 3 modulator tick
   task automatic wait_on(input int w, input int lim, output logic got);
      got = 1'b0;
      for (int k = 0; k < lim && !got; k++)
      begin
         @(negedge clk_in);
         got = (w == 0) ? frst === 1'b1 : (w == 1) ? rdy_n === 1'b0 :
               (w == 2) ? res_v === 1'b1 : tick === 1'b1;
      end
   endtask

   task automatic cal(input logic [2:0] code);
      logic got;
      hist.delete();
      cmd(code);
      wait_on(0, 4, got);
      check(got, 1'b1);
      check(rdy_n, 1'b1);
      // Ready is meaningless for one modulator cycle after the command
      repeat (MDIV) @(posedge clk_in);
      wait_on(1, 8000, got);
      check(got, 1'b1);
      while (hist.size() < 2)
         hist.push_back(2'h3);
   endtask

   initial
   begin
      sys_rst_in = 1'b1;
      {mode, mode_wr, bipolar, gain_sel, off_wr, gain_wr} = '0;
      {coef, ain} = '0;
      sync_n = 1'b1;
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      check(ocoef, OFFSET_RST);
      check(gcoef, GAIN_RST);
      wait_on(3, 4 * MDIV, hit);
      for (i = 1; i < 4 * MDIV; i++)
      begin
         @(negedge clk_in);
         if (tick === 1'b1)
            break;
      end
      check(i, MDIV);
      $display("test reset and tick done");
      wcoef(24'h000100, 24'h400000);
      ain <= 24'h100300;
      wait_on(2, 500, hit);
      wait_on(2, 500, hit);
      check(res, 24'h080100);
      $display("test result path done");
      @(posedge clk_in);
      gain_sel <= 3'h5;
      wcoef(PO, PG);
      cal(3'h1);
      check(hist[0], SRC_SHORT);
      check(hist[1], SRC_REF);
      check(sel, SRC_AIN);
      check(cgain, 3'h5);
      check(ocoef, SHORT);
      check(gcoef, G_EXP);
      @(posedge clk_in);
      bipolar <= 1'b1;
      gain_sel <= 3'h2;
      cal(3'h1);
      check(cgain, 3'h2);
      @(posedge clk_in);
      bipolar <= 1'b0;
      $display("test self calibration done");
      wcoef(PO, PG);
      ain <= 24'h000200;
      cal(3'h2);
      check(ocoef, 24'h000200);
      wcoef(24'h000200, PG);
      ain <= 24'h800200;
      cal(3'h3);
      check(gcoef, G_EXP);
      @(posedge clk_in);
      ain <= 24'h000300;
      cal(3'h2);
      check(ocoef, 24'h000300);
      check(gcoef, G_EXP);
      $display("test system calibration done");
      wcoef(PO, PG);
      ain <= SHORT;
      cal(3'h4);
      check(ocoef, SHORT);
      check(gcoef, G_EXP);
      $display("test offset calibration done");
      wcoef(PO, PG);
      for (i = 0; i < 3; i++)
      begin
         cmd((i == 0) ? 3'h0 : 3'(i + 5));
         wait_on(0, 6, hit);
         check(hit, 1'b0);
      end
      check(ocoef, PO);
      check(gcoef, PG);
      check(busy, 1'b0);
      $display("test unused codes done");
      @(posedge clk_in);
      sync_n <= 1'b0;
      wait_on(0, 6, hit);
      check(hit, 1'b1);
      @(posedge clk_in);
      sync_n <= 1'b1;
      $display("test sync done");
      wcoef(PO, PG);
      cmd(3'h5);
      wait_on(0, 4, hit);
      check(hit, 1'b1);
      repeat (3000) @(negedge clk_in);
      check(ocoef, SHORT);
      check(gcoef, G_EXP);
      cmd(3'h0);
      $display("test background done");
      end_of_test();
   end

   // Whole run needs about 5000 cycles
   initial
   begin
      repeat (80000) @(posedge clk_in);
      n_errors++;
      end_of_test();
   end
endmodule
